// ==== rtl/pciow_cyc_if.sv ====
`default_nettype none
// one card cycle request from the top to the timer, and its progress back
interface pciow_cyc_if;
	logic                        start;
	logic                        sock;
	logic                        win;
	logic                        width16;
	logic [pciow_pkg::LEN_W-1:0] len;
	logic                        busy;
	logic                        done;
	logic                        sock_q;
	logic                        win_q;
	logic                        width16_q;

	modport src (
		output start, sock, win, width16, len,
		input  busy, done, sock_q, win_q, width16_q
	);
	modport tim (
		input  start, sock, win, width16, len,
		output busy, done, sock_q, win_q, width16_q
	);
endinterface
`default_nettype wire

// ==== rtl/pciow_cycle_timer.sv ====
`default_nettype none
// holds a claimed card cycle busy for its programmed length
module pciow_cycle_timer (
	input  wire logic  i_clk,
	input  wire logic  i_sys_rst,
	input  wire logic  i_clk_en,
	pciow_cyc_if.tim   cyc
);
	typedef struct packed {
		pciow_pkg::pciow_tim_state_t st;
		logic [pciow_pkg::LEN_W-1:0] cnt;
		logic [pciow_pkg::LEN_W-1:0] len;
		logic [pciow_pkg::LEN_W-1:0] elapsed;
		logic                        sock;
		logic                        win;
		logic                        width16;
	} pciow_tim_t;

	pciow_tim_t q;
	pciow_tim_t d;
	logic       last;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d    = q;
		last = 1'b0;
		case (q.st)
			pciow_pkg::TIM_IDLE: begin
				if (cyc.start) begin
					d.st      = pciow_pkg::TIM_RUN;
					d.cnt     = cyc.len - 1'b1;
					d.len     = cyc.len;
					d.elapsed = '0;
					d.sock    = cyc.sock;
					d.win     = cyc.win;
					d.width16 = cyc.width16;
				end
			end
			pciow_pkg::TIM_RUN: begin
				d.elapsed = q.elapsed + 1'b1;
				if (q.cnt == '0) begin
					last = 1'b1;
					d.st = pciow_pkg::TIM_IDLE;
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			default: d.st = pciow_pkg::TIM_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// state register, frozen while the enable is low
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= '{st: pciow_pkg::TIM_IDLE, default: '0};
		end else if (i_clk_en) begin
			q <= d;
		end
	end

	assign cyc.busy      = (q.st == pciow_pkg::TIM_RUN);
	assign cyc.done      = last && i_clk_en; // a frozen cycle must not report completion
	assign cyc.sock_q    = q.sock;
	assign cyc.win_q     = q.win;
	assign cyc.width16_q = q.width16;

	a_busy_length: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cyc.done |-> q.elapsed == q.len - 1'b1)
		else $error("cycle ended off its programmed length");
	a_start_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(cyc.start && i_clk_en && !cyc.busy) |=> cyc.busy && q.len == $past(cyc.len))
		else $error("claimed cycle did not start");
endmodule
`default_nettype wire

// ==== rtl/pciow_pkg.sv ====
`default_nettype none
package pciow_pkg;

	// ----------------------------------------------------------------
	// register map, byte offsets inside one socket
	// ----------------------------------------------------------------
	localparam logic [5:0]  OFF_CTRL    = 6'h07;
	localparam logic [5:0]  OFF_W0_SLO  = 6'h08;
	localparam logic [5:0]  OFF_W0_SHI  = 6'h09;
	localparam logic [5:0]  OFF_W0_ELO  = 6'h0a;
	localparam logic [5:0]  OFF_W0_EHI  = 6'h0b;
	localparam logic [5:0]  OFF_W1_SLO  = 6'h0c;
	localparam logic [5:0]  OFF_W1_SHI  = 6'h0d;
	localparam logic [5:0]  OFF_W1_ELO  = 6'h0e;
	localparam logic [5:0]  OFF_W1_EHI  = 6'h0f;
	localparam logic [5:0]  OFF_FIRST   = OFF_CTRL;
	localparam logic [5:0]  OFF_LAST    = OFF_W1_EHI;
	localparam int          NUM_REGS    = 9;
	localparam logic [11:0] SOCK_STRIDE = 12'h040;
	localparam logic [11:0] SOCK_SPAN   = 12'h080;
	localparam logic [11:0] ALIAS_BASE  = 12'h800;
	localparam logic [11:0] PAGE_MASK   = 12'hfc0;
	localparam logic [7:0]  REG_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// storage index layout and control field positions
	// ----------------------------------------------------------------
	localparam int IDX_CTRL       = 0;
	localparam int IDX_SLO        = 1;
	localparam int IDX_SHI        = 2;
	localparam int IDX_ELO        = 3;
	localparam int IDX_EHI        = 4;
	localparam int IDX_WIN_STRIDE = 4;
	localparam int BIT_WSEL       = 0;
	localparam int BIT_AUTO       = 1;
	localparam int BIT_FAST       = 2;
	localparam int BIT_WAIT       = 3;
	localparam int WIN_BIT_STRIDE = 4;

	// ----------------------------------------------------------------
	// card cycle timing, in ISA cycles then clock cycles
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int ISA_CYCLE_NS  = 120;
	localparam int ISA_CLKS      = (ISA_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STD8_ISA      = 6;
	localparam int FAST8_ISA     = 3;
	localparam int STD16_ISA     = 3;
	localparam int EXT16_ISA     = STD16_ISA + 1;
	localparam int LEN_W         = 7;
	localparam logic [LEN_W-1:0] LEN_STD8  = LEN_W'(STD8_ISA * ISA_CLKS);
	localparam logic [LEN_W-1:0] LEN_FAST8 = LEN_W'(FAST8_ISA * ISA_CLKS);
	localparam logic [LEN_W-1:0] LEN_STD16 = LEN_W'(STD16_ISA * ISA_CLKS);
	localparam logic [LEN_W-1:0] LEN_EXT16 = LEN_W'(EXT16_ISA * ISA_CLKS);

	typedef enum logic {
		TIM_IDLE,
		TIM_RUN
	} pciow_tim_state_t;

endpackage
`default_nettype wire

// ==== rtl/pciow_top.sv ====
`default_nettype none
// two-socket I/O window configuration bank with window decode and cycle timing
module pciow_top (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_clk_en,
	input  wire logic [11:0]      i_reg_addr,
	input  wire logic             i_reg_wr,
	input  wire logic             i_reg_rd,
	input  wire logic [7:0]       i_reg_wdata,
	output logic      [7:0]       o_reg_rdata,
	output logic                  o_reg_ack,
	input  wire logic [1:0][1:0]  i_win_en,
	input  wire logic             i_io_req,
	input  wire logic             i_io_sock,
	input  wire logic [15:0]      i_io_addr,
	input  wire logic [1:0]       i_card_io16,
	output logic                  o_io_claim,
	output logic                  o_io_busy,
	output logic                  o_io_done,
	output logic                  o_io_sock,
	output logic                  o_io_win,
	output logic                  o_io_width16
);
	typedef struct packed {
		logic [1:0][pciow_pkg::NUM_REGS-1:0][7:0] regs;
		logic [7:0]                               rdata;
		logic                                     ack;
	} pciow_state_t;

	pciow_state_t                     state_q;
	pciow_state_t                     state_d;
	logic                             alias_hit;
	logic                             direct_hit;
	logic                             mapped;
	logic                             sock_sel;
	logic [5:0]                       off;
	logic [3:0]                       idx;
	logic [1:0]                       hit;
	logic [1:0]                       win;
	logic [1:0]                       w16;
	logic [1:0][pciow_pkg::LEN_W-1:0] len;

	pciow_cyc_if u_cyc ();

	// ----------------------------------------------------------------
	// register address decode
	// ----------------------------------------------------------------
	// socket A answers both at its own page and at the alias page
	always_comb begin
		alias_hit  = (i_reg_addr & pciow_pkg::PAGE_MASK) == pciow_pkg::ALIAS_BASE;
		direct_hit = i_reg_addr < pciow_pkg::SOCK_SPAN;
		off        = i_reg_addr[5:0];
		sock_sel   = alias_hit ? 1'b0 : (i_reg_addr >= pciow_pkg::SOCK_STRIDE);
		mapped     = (alias_hit || direct_hit) &&
			(off >= pciow_pkg::OFF_FIRST) && (off <= pciow_pkg::OFF_LAST);
		idx        = 4'(off - pciow_pkg::OFF_FIRST);
	end

	// ----------------------------------------------------------------
	// register bank next state
	// ----------------------------------------------------------------
	// every byte is plain read/write; a read in the same cycle as a write
	// returns the old value, which keeps the read path free of the write mux
	always_comb begin
		state_d     = state_q;
		state_d.ack = i_reg_wr || i_reg_rd;
		if (i_reg_wr && mapped) begin
			state_d.regs[sock_sel][idx] = i_reg_wdata;
		end
		if (i_reg_rd) begin
			state_d.rdata = mapped ? state_q.regs[sock_sel][idx] : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q <= '{regs: {(2 * pciow_pkg::NUM_REGS){pciow_pkg::REG_RESET}},
				rdata: 8'h00, ack: 1'b0};
		end else if (i_clk_en) begin
			state_q <= state_d;
		end
	end

	assign o_reg_rdata = state_q.rdata;
	assign o_reg_ack   = state_q.ack;

	// ----------------------------------------------------------------
	// window decode per socket
	// ----------------------------------------------------------------
	for (genvar s = 0; s < 2; s++) begin : g_sock
		pciow_win_decode u_dec (
			.i_cfg       (state_q.regs[s]),
			.i_win_en    (i_win_en[s]),
			.i_addr      (i_io_addr),
			.i_card_io16 (i_card_io16[s]),
			.o_hit       (hit[s]),
			.o_win       (win[s]),
			.o_width16   (w16[s]),
			.o_len       (len[s])
		);
	end

	// ----------------------------------------------------------------
	// claim and hand the cycle to the timer
	// ----------------------------------------------------------------
	// a request during a running card cycle is not claimed; the host retries
	assign o_io_claim    = i_io_req && hit[i_io_sock] && !u_cyc.busy && i_clk_en;
	assign u_cyc.start   = o_io_claim;
	assign u_cyc.sock    = i_io_sock;
	assign u_cyc.win     = win[i_io_sock];
	assign u_cyc.width16 = w16[i_io_sock];
	assign u_cyc.len     = len[i_io_sock];

	pciow_cycle_timer u_tim (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.cyc       (u_cyc.tim)
	);

	assign o_io_busy    = u_cyc.busy;
	assign o_io_done    = u_cyc.done;
	assign o_io_sock    = u_cyc.sock_q;
	assign o_io_win     = u_cyc.win_q;
	assign o_io_width16 = u_cyc.width16_q;

	// ----------------------------------------------------------------
	// checks on the claimed window and on the register bank
	// ----------------------------------------------------------------
	logic [pciow_pkg::NUM_REGS-1:0][7:0] ck_cfg;
	logic [3:0]                          ck_nib;
	logic [15:0]                         ck_start;
	logic [15:0]                         ck_end;
	int                                  ck_base;

	always_comb begin
		ck_cfg   = state_q.regs[i_io_sock];
		ck_base  = u_cyc.win ? pciow_pkg::IDX_WIN_STRIDE : 0;
		ck_nib   = u_cyc.win ? ck_cfg[pciow_pkg::IDX_CTRL][7:4] : ck_cfg[pciow_pkg::IDX_CTRL][3:0];
		ck_start = {ck_cfg[pciow_pkg::IDX_SHI + ck_base], ck_cfg[pciow_pkg::IDX_SLO + ck_base]};
		ck_end   = {ck_cfg[pciow_pkg::IDX_EHI + ck_base], ck_cfg[pciow_pkg::IDX_ELO + ck_base]};
	end

	a_claim_enabled: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_io_claim |-> i_win_en[i_io_sock][u_cyc.win])
		else $error("claim through a disabled window");
	a_claim_in_range: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_io_claim |-> (i_io_addr >= ck_start) && (i_io_addr <= ck_end))
		else $error("claim outside window bounds");
	a_width_auto: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(o_io_claim && ck_nib[pciow_pkg::BIT_AUTO])
		|=> o_io_width16 == $past(i_card_io16[i_io_sock]))
		else $error("auto size did not follow card width");
	a_width_fixed: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(o_io_claim && !ck_nib[pciow_pkg::BIT_AUTO])
		|-> u_cyc.width16 == ck_nib[pciow_pkg::BIT_WSEL])
		else $error("fixed width select not honoured");
	a_wait_extend: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(o_io_claim && u_cyc.width16)
		|-> u_cyc.len == (ck_nib[pciow_pkg::BIT_WAIT] ? pciow_pkg::LEN_EXT16
			: pciow_pkg::LEN_STD16))
		else $error("16-bit cycle length wrong");
	a_fast_byte: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(o_io_claim && !u_cyc.width16)
		|-> u_cyc.len == (ck_nib[pciow_pkg::BIT_FAST] ? pciow_pkg::LEN_FAST8
			: pciow_pkg::LEN_STD8))
		else $error("8-bit cycle length wrong");
	a_reg_write_back: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_clk_en && i_reg_wr && mapped)
		|=> state_q.regs[$past(sock_sel)][$past(idx)] == $past(i_reg_wdata))
		else $error("register write lost");
	a_sock_b_stride: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_clk_en && i_reg_wr && i_reg_addr == pciow_pkg::SOCK_STRIDE + 12'(pciow_pkg::OFF_CTRL))
		|=> state_q.regs[1][pciow_pkg::IDX_CTRL] == $past(i_reg_wdata))
		else $error("second socket control write misplaced");
	a_alias_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_clk_en && i_reg_rd && alias_hit && mapped)
		|=> o_reg_rdata == $past(state_q.regs[0][idx]) && o_reg_ack)
		else $error("alias read does not mirror first socket");
	a_unmapped_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(i_clk_en && i_reg_rd && !mapped) |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ==== rtl/pciow_win_decode.sv ====
`default_nettype none
// combinational hit, width and length lookup for one socket's two windows
module pciow_win_decode (
	input  wire logic [pciow_pkg::NUM_REGS-1:0][7:0] i_cfg,
	input  wire logic [1:0]                          i_win_en,
	input  wire logic [15:0]                         i_addr,
	input  wire logic                                i_card_io16,
	output logic                                     o_hit,
	output logic                                     o_win,
	output logic                                     o_width16,
	output logic [pciow_pkg::LEN_W-1:0]              o_len
);
	logic [1:0]                        hit_w;
	logic [1:0]                        w16_w;
	logic [1:0][pciow_pkg::LEN_W-1:0]  len_w;

	// ----------------------------------------------------------------
	// per window compare and cycle shaping
	// ----------------------------------------------------------------
	for (genvar w = 0; w < 2; w++) begin : g_win
		localparam int B = w * pciow_pkg::IDX_WIN_STRIDE;
		localparam int F = w * pciow_pkg::WIN_BIT_STRIDE;
		logic [15:0] start_a;
		logic [15:0] end_a;
		logic        auto_sz;
		logic        wsel;
		logic        fast;
		logic        wait_x;
		assign start_a = {i_cfg[pciow_pkg::IDX_SHI + B], i_cfg[pciow_pkg::IDX_SLO + B]};
		assign end_a   = {i_cfg[pciow_pkg::IDX_EHI + B], i_cfg[pciow_pkg::IDX_ELO + B]};
		assign auto_sz = i_cfg[pciow_pkg::IDX_CTRL][pciow_pkg::BIT_AUTO + F];
		assign wsel    = i_cfg[pciow_pkg::IDX_CTRL][pciow_pkg::BIT_WSEL + F];
		assign fast    = i_cfg[pciow_pkg::IDX_CTRL][pciow_pkg::BIT_FAST + F];
		assign wait_x  = i_cfg[pciow_pkg::IDX_CTRL][pciow_pkg::BIT_WAIT + F];
		// enable gates before the compare, so stale bounds never leak a claim
		assign hit_w[w] = i_win_en[w] && (i_addr >= start_a) && (i_addr <= end_a);
		// fixed width select is ignored while auto sizing is on
		assign w16_w[w] = auto_sz ? i_card_io16 : wsel;
		// wait bit only touches 16-bit, fast bit only 8-bit
		assign len_w[w] = w16_w[w] ?
			(wait_x ? pciow_pkg::LEN_EXT16 : pciow_pkg::LEN_STD16) :
			(fast ? pciow_pkg::LEN_FAST8 : pciow_pkg::LEN_STD8);
	end

	// window 0 wins when both match an overlapping range
	always_comb begin
		o_hit     = |hit_w;
		o_win     = !hit_w[0];
		o_width16 = hit_w[0] ? w16_w[0] : w16_w[1];
		o_len     = hit_w[0] ? len_w[0] : len_w[1];
	end
endmodule
`default_nettype wire

// ==== tb/pciow_card_model.sv ====
`default_nettype none
// behavioural 16-bit card for both sockets: each socket reports a 16-bit or
// an 8-bit port on its size line, as the bench selects, one clock after the change
module pciow_card_model (
	input  wire logic       i_clk,
	input  wire logic [1:0] i_io16_sel,
	output var logic  [1:0] o_card_io16
);
	timeunit 1ns;
	timeprecision 1ps;

	// registered so the size line moves like a card pin, never in the claim cycle;
	// unknown until the first edge, which falls inside reset where nothing is claimed
	always_ff @(posedge i_clk) begin
		o_card_io16 <= i_io16_sel;
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic            clk;
	logic            sys_rst;
	logic            clk_en;
	logic [11:0]     reg_addr;
	logic            reg_wr;
	logic            reg_rd;
	logic [7:0]      reg_wdata;
	logic [7:0]      reg_rdata;
	logic            reg_ack;
	logic [1:0][1:0] win_en;
	logic            io_req;
	logic            io_sock;
	logic [15:0]     io_addr;
	logic [1:0]      card_sel;
	logic [1:0]      card_io16;
	logic            io_claim;
	logic            io_busy;
	logic            io_done;
	logic            io_sock_q;
	logic            io_win;
	logic            io_width16;
	int              failures;
	int              checks_done;
	int              cycles;
	logic [7:0]      win_val [8];

	pciow_top i_dut (
		.i_clk        (clk),
		.i_sys_rst    (sys_rst),
		.i_clk_en     (clk_en),
		.i_reg_addr   (reg_addr),
		.i_reg_wr     (reg_wr),
		.i_reg_rd     (reg_rd),
		.i_reg_wdata  (reg_wdata),
		.o_reg_rdata  (reg_rdata),
		.o_reg_ack    (reg_ack),
		.i_win_en     (win_en),
		.i_io_req     (io_req),
		.i_io_sock    (io_sock),
		.i_io_addr    (io_addr),
		.i_card_io16  (card_io16),
		.o_io_claim   (io_claim),
		.o_io_busy    (io_busy),
		.o_io_done    (io_done),
		.o_io_sock    (io_sock_q),
		.o_io_win     (io_win),
		.o_io_width16 (io_width16)
	);

	pciow_card_model i_card (
		.i_clk       (clk),
		.i_io16_sel  (card_sel),
		.o_card_io16 (card_io16)
	);

	// ------------------------------------------------------------
	// clock, hang guard and verdict
	// ------------------------------------------------------------
	initial clk = 1'b0;
	always #4 clk = ~clk;

	// whole run needs about 1300 cycles; a stuck busy ends at the 200-cycle loop cap, this catches other hangs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// ------------------------------------------------------------
	// register port: strobe one cycle, ack and data on the next
	// ------------------------------------------------------------
	task automatic reg_acc(input logic wr, input logic [11:0] a, input logic [7:0] d,
		input logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_wr = wr;
		reg_rd = ~wr;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		chk("register ack", 16'h0001, 16'(reg_ack));
		if (!wr) chk("register read data", 16'(exp), 16'(reg_rdata));
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_acc(1'b1, a, d, 8'h00);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		reg_acc(1'b0, a, 8'h00, exp);
	endtask

	// ------------------------------------------------------------
	// host io cycle: request held through busy must never be claimed again
	// ------------------------------------------------------------
	task automatic io_cycle(input logic s, input logic [15:0] a, input logic ec,
		input logic ew, input logic e16, input int el);
		int   n;
		int   done_at;
		logic bad;
		n = 0;
		done_at = 0;
		bad = 1'b0;
		@(negedge clk);
		io_sock = s;
		io_addr = a;
		io_req = 1'b1;
		#1;
		chk("claim", 16'(ec), 16'(io_claim));
		if (!ec) begin
			io_req = 1'b0;
			return;
		end
		@(negedge clk);
		chk("cycle socket", 16'(s), 16'(io_sock_q));
		chk("cycle window", 16'(ew), 16'(io_win));
		chk("cycle width", 16'(e16), 16'(io_width16));
		while (io_busy === 1'b1 && n < 200) begin
			n++;
			if (io_claim !== 1'b0) bad = 1'b1;
			if (io_done === 1'b1) begin
				done_at = n;
				io_req = 1'b0;
			end
			@(negedge clk);
		end
		io_req = 1'b0;
		chk("busy cycles", 16'(el), 16'(n));
		chk("done position", 16'(el), 16'(done_at));
		chk("claim while busy", 16'h0000, 16'(bad));
	endtask

	// program one socket's control, set the card size lines opposite per socket
	task automatic run_case(input logic s, input logic w, input logic [7:0] ctrl,
		input logic io16, input logic e16, input int el);
		card_sel = s ? {io16, ~io16} : {~io16, io16};
		wr({5'h00, s, 6'h07}, ctrl);
		io_cycle(s, w ? 16'h0350 : 16'h0150, 1'b1, w, e16, el);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		failures = 0;
		checks_done = 0;
		cycles = 0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		reg_addr = 12'h000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		win_en = 4'h0;
		io_req = 1'b0;
		io_sock = 1'b0;
		io_addr = 16'h0000;
		card_sel = 2'h0;
		win_val = '{8'h00, 8'h01, 8'hff, 8'h01, 8'h00, 8'h03, 8'hff, 8'h03};
		repeat (4) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		// every register of both sockets and the alias comes up zero
		for (int o = 7; o < 16; o++) begin
			rd(12'(o), 8'h00);
			rd(12'h040 + 12'(o), 8'h00);
			rd(12'h800 + 12'(o), 8'h00);
		end
		// unmapped places are acked, ignore writes and read zero
		wr(12'h010, 8'h5a);
		rd(12'h010, 8'h00);
		rd(12'h006, 8'h00);
		// socket copies are separate, alias reaches socket A in both directions
		wr(12'h007, 8'h5a);
		wr(12'h047, 8'ha5);
		rd(12'h807, 8'h5a);
		rd(12'h047, 8'ha5);
		wr(12'h807, 8'h3c);
		rd(12'h007, 8'h3c);
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 8; i++) wr(12'(s * 64 + 8 + i), win_val[i]);
		end
		for (int i = 0; i < 8; i++) begin
			rd(12'h808 + 12'(i), win_val[i]);
			rd(12'h048 + 12'(i), win_val[i]);
		end
		win_en = 4'hf;
		// window 0 timing and width, every control bit on and off
		run_case(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 90);
		run_case(1'b0, 1'b0, 8'h04, 1'b0, 1'b0, 45);
		run_case(1'b0, 1'b0, 8'h01, 1'b0, 1'b1, 45);
		run_case(1'b0, 1'b0, 8'h09, 1'b0, 1'b1, 60);
		run_case(1'b0, 1'b0, 8'h08, 1'b0, 1'b0, 90);
		run_case(1'b0, 1'b0, 8'h05, 1'b0, 1'b1, 45);
		run_case(1'b0, 1'b0, 8'h03, 1'b0, 1'b0, 90);
		run_case(1'b0, 1'b0, 8'h02, 1'b1, 1'b1, 45);
		// window 1 uses the upper nibble and ignores the lower one
		run_case(1'b0, 1'b1, 8'h90, 1'b0, 1'b1, 60);
		run_case(1'b0, 1'b1, 8'h40, 1'b0, 1'b0, 45);
		run_case(1'b0, 1'b1, 8'h30, 1'b0, 1'b0, 90);
		run_case(1'b0, 1'b1, 8'h20, 1'b1, 1'b1, 45);
		run_case(1'b0, 1'b1, 8'h0f, 1'b1, 1'b0, 90);
		// socket B takes its own card size line
		run_case(1'b1, 1'b0, 8'h02, 1'b1, 1'b1, 45);
		// window bounds are inclusive at both ends
		wr(12'h007, 8'h11);
		io_cycle(1'b0, 16'h0100, 1'b1, 1'b0, 1'b1, 45);
		io_cycle(1'b0, 16'h01ff, 1'b1, 1'b0, 1'b1, 45);
		io_cycle(1'b0, 16'h00ff, 1'b0, 1'b0, 1'b0, 0);
		io_cycle(1'b0, 16'h0200, 1'b0, 1'b0, 1'b0, 0);
		io_cycle(1'b0, 16'h03ff, 1'b1, 1'b1, 1'b1, 45);
		// a write strobe while the enable is low is neither taken nor acked;
		// one idle edge first so the previous ack has already dropped
		@(negedge clk);
		clk_en = 1'b0;
		reg_addr = 12'h007;
		reg_wdata = 8'hee;
		reg_wr = 1'b1;
		@(negedge clk);
		chk("frozen ack", 16'h0000, 16'(reg_ack));
		reg_wr = 1'b0;
		clk_en = 1'b1;
		rd(12'h007, 8'h11);
		// a disabled window is never claimed, the same window of socket B still is
		win_en = 4'b1110;
		io_cycle(1'b0, 16'h0150, 1'b0, 1'b0, 1'b0, 0);
		io_cycle(1'b1, 16'h0150, 1'b1, 1'b0, 1'b1, 45);
		win_en = 4'b0011;
		io_cycle(1'b1, 16'h0350, 1'b0, 1'b0, 1'b0, 0);
		wrap_up();
	end
endmodule
`default_nettype wire
